/* core/boost_supervisor_pkg.sv */
// constants, offsets and types shared by the boost fault supervisor
package boost_supervisor_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 40_000_000;  // core clock rate
   localparam int unsigned PULSE_US        = 128;         // fault pulse width, us
   localparam int unsigned PULSE_CYC       = (CLK_HZ / 1_000_000) * PULSE_US;
   localparam int unsigned OVLD_MS         = 30;          // overload persistence, ms
   localparam int unsigned OVLD_CYC        = (CLK_HZ / 1_000) * OVLD_MS;
   localparam int unsigned TICK_HZ         = 1_000;       // millisecond tick rate
   localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam int unsigned SAFETY_S        = 32;          // boost safety timer, s
   localparam int unsigned SAFETY_TICKS    = SAFETY_S * TICK_HZ;
   localparam int unsigned CRUDE_S         = 32;          // crude host timer, s
   localparam int unsigned CRUDE_TICKS     = CRUDE_S * TICK_HZ;

   // ****************************************
   // avalon register map (byte addresses)
   // ****************************************
   localparam logic [3:0] ADDR_CTRL     = 4'h0;  // control bits
   localparam logic [3:0] ADDR_STATUS   = 4'h4;  // mode and fault code
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;  // sticky events, write one to clear
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;  // interrupt enables

   // control register fields
   localparam int unsigned CTRL_BOOST_POS = 0;   // boost_select_bit
   localparam int unsigned CTRL_HIZ_POS   = 1;   // hiz_request_bit
   localparam int unsigned CTRL_KICK_POS  = 2;   // timer_kick_bit, self clearing
   localparam int unsigned CTRL_FCLR_POS  = 3;   // fault clear, self clearing

   // event bits in irq status / mask
   localparam int unsigned EV_FAULT_POS   = 0;   // any boost fault
   localparam int unsigned EV_CRUDE_POS   = 1;   // crude timer expired
   localparam int unsigned EV_W           = 2;

   localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
   localparam logic [1:0]  RESET_MASK = 2'h0;

   // fault codes
   typedef enum logic [2:0] {
      FLT_NONE     = 3'h0,
      FLT_OUT_OV   = 3'h1,
      FLT_OVERLOAD = 3'h2,
      FLT_BAT_OV   = 3'h3,
      FLT_BAT_LOW  = 3'h4,
      FLT_TIMER    = 3'h5
   } fault_code_e;

   // operating modes
   typedef enum logic [1:0] {
      MODE_CHARGE,
      MODE_BOOST,
      MODE_HIZ,
      MODE_CHG_CFG
   } op_mode_e;

endpackage

/* core/boost_supervisor.sv */
// boost mode fault supervisor with hi-z and crude host-presence timer
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module boost_supervisor (
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_b_i,
   // avalon-mm slave
   input  wire logic [3:0]           avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output logic      [31:0]          avs_readdata_o,
   output logic                      avs_waitrequest_o,
   // pins and analog comparators
   input  wire logic                 otg_active_i,
   input  wire logic                 out_ov_i,
   input  wire logic                 overload_i,
   input  wire logic                 bat_ov_i,
   input  wire logic                 bat_min_i,
   input  wire logic                 bat_low_i,
   input  wire logic                 vin_input_undervoltage_lockout_i,
   // converter controls
   output logic                      boost_en_o,
   output logic                      pass_switch_linear_o,
   output logic                      hiz_o,
   output boost_supervisor_pkg::op_mode_e mode_o,
   // status pin, open drain
   output logic                      stat_out_o,
   output logic                      stat_oe_o,
   // interrupt
   output logic                      irq_o
);
   import boost_supervisor_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int unsigned NIN = 7;
   logic [NIN-1:0] raw_in;       // asynchronous inputs
   logic [NIN-1:0] sync1;        // first stage, read only by sync2
   logic [NIN-1:0] sync2;        // second stage
   logic [NIN-1:0] sync3;        // third stage
   logic [NIN-1:0] in_q;         // accepted level

   assign raw_in = {vin_input_undervoltage_lockout_i, bat_low_i, bat_min_i, bat_ov_i,
                    overload_i, out_ov_i, otg_active_i};

   // three flops, level accepted once stages two and three agree
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_accept
         // per-bit agreement filter
         always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               in_q[gi] <= 1'b0;
            end else if (sync2[gi] == sync3[gi]) begin
               in_q[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   logic otg, out_ov, ovld, bat_ov, bat_min, bat_low, input_undervoltage_lockout;
   assign {input_undervoltage_lockout, bat_low, bat_min, bat_ov, ovld, out_ov, otg} = in_q;

   // ****************************************
   // register bus
   // ****************************************
   logic               boost_sel;    // boost_select_bit
   logic               hiz_req;      // hiz_request_bit
   logic               kick;         // timer_kick_bit pulse
   logic               fault_clr;    // fault clear pulse
   logic [EV_W-1:0]    irq_stat;     // sticky events
   logic [EV_W-1:0]    irq_mask;     // event enables
   logic               wr_ctrl;      // control write strobe
   logic               wr_stat;      // irq status write strobe
   logic               wr_mask;      // mask write strobe
   fault_code_e        fault_code;   // held fault cause
   logic               min32_mode;   // 32 minute mode
   logic               fault_evt;    // one-cycle fault event
   fault_code_e        fault_cause;  // cause of this event
   logic               crude_evt;    // crude timer expiry pulse
   op_mode_e           mode;         // current mode

   // single cycle answer, never stalls
   assign avs_waitrequest_o = 1'b0;
   assign wr_ctrl = avs_write_i && avs_byteenable_i[0] && (avs_address_i == ADDR_CTRL);
   assign wr_stat = avs_write_i && avs_byteenable_i[0] && (avs_address_i == ADDR_IRQ_STAT);
   assign wr_mask = avs_write_i && avs_byteenable_i[0] && (avs_address_i == ADDR_IRQ_MASK);

   // read data combinational from registers, valid in the request cycle
   always_comb begin
      avs_readdata_o = 32'h0000_0000;
      unique case (avs_address_i)
         ADDR_CTRL:     avs_readdata_o = {30'h0000_0000, hiz_req, boost_sel};
         ADDR_STATUS:   avs_readdata_o = {26'h000_0000, min32_mode, mode, fault_code};
         ADDR_IRQ_STAT: avs_readdata_o = {30'h0000_0000, irq_stat};
         ADDR_IRQ_MASK: avs_readdata_o = {30'h0000_0000, irq_mask};
         default:       avs_readdata_o = 32'h0000_0000;  // unmapped reads zero
      endcase
   end

   // control bits; hardware clear of boost select wins on a fault
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         boost_sel <= RESET_CTRL[CTRL_BOOST_POS];
         hiz_req   <= RESET_CTRL[CTRL_HIZ_POS];
      end else begin
         if (wr_ctrl) begin
            boost_sel <= avs_writedata_i[CTRL_BOOST_POS];
            hiz_req   <= avs_writedata_i[CTRL_HIZ_POS];
         end
         if (fault_evt) begin
            boost_sel <= 1'b0;
         end
      end
   end

   // self clearing command pulses
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         kick      <= 1'b0;
         fault_clr <= 1'b0;
      end else begin
         kick      <= wr_ctrl && avs_writedata_i[CTRL_KICK_POS];
         fault_clr <= wr_ctrl && avs_writedata_i[CTRL_FCLR_POS];
      end
   end

   // mask register
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_mask <= RESET_MASK;
      end else if (wr_mask) begin
         irq_mask <= avs_writedata_i[EV_W-1:0];
      end
   end

   // sticky events, set wins over write-one-clear
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat <= '0;
      end else begin
         for (int i = 0; i < EV_W; i++) begin
            if (wr_stat && avs_writedata_i[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
         if (fault_evt) irq_stat[EV_FAULT_POS] <= 1'b1;
         if (crude_evt) irq_stat[EV_CRUDE_POS] <= 1'b1;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // ****************************************
   // timebase and timers
   // ****************************************
   logic [15:0] tick_cnt;   // divider to 1 ms
   logic        tick;       // 1 ms enable pulse
   logic [20:0] ovld_cnt;   // overload persistence counter, holds limit plus one
   logic [15:0] safety_cnt; // boost safety timer, ms
   logic [15:0] crude_cnt;  // crude host timer, ms
   logic        boosting;   // converter running

   // millisecond enable pulse
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick     <= 1'b0;
      end
   end

   // overload must persist past the limit before it is a fault
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ovld_cnt <= '0;
      end else if (!(boosting && ovld)) begin
         ovld_cnt <= '0;
      end else if (ovld_cnt <= 21'(OVLD_CYC)) begin
         ovld_cnt <= ovld_cnt + 21'h0_0001;
      end
   end

   // safety timer, restarted at boost entry and by kick
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         safety_cnt <= '0;
      end else if (!boosting || kick) begin
         safety_cnt <= '0;
      end else if (tick && safety_cnt < 16'(SAFETY_TICKS)) begin
         safety_cnt <= safety_cnt + 16'h0001;
      end
   end

   // crude timer runs in hi-z below low battery, stops in 32 min mode
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         crude_cnt  <= '0;
         min32_mode <= 1'b0;
         crude_evt  <= 1'b0;
      end else begin
         crude_evt <= 1'b0;
         if (min32_mode || mode != MODE_HIZ || !bat_low) begin
            crude_cnt <= '0;
         end else if (tick) begin
            if (crude_cnt == 16'(CRUDE_TICKS - 1)) begin
               min32_mode <= 1'b1;
               crude_evt  <= 1'b1;
            end else begin
               crude_cnt <= crude_cnt + 16'h0001;
            end
         end
      end
   end

   // ****************************************
   // fault detection and mode
   // ****************************************
   // fault causes in priority order
   always_comb begin
      fault_cause = FLT_NONE;
      if (out_ov)                                      fault_cause = FLT_OUT_OV;
      else if (ovld_cnt > 21'(OVLD_CYC))               fault_cause = FLT_OVERLOAD;
      else if (bat_ov)                                 fault_cause = FLT_BAT_OV;
      else if (bat_min)                                fault_cause = FLT_BAT_LOW;
      else if (safety_cnt >= 16'(SAFETY_TICKS))        fault_cause = FLT_TIMER;
   end

   assign fault_evt = boosting && (fault_cause != FLT_NONE);

   // held fault code; a new fault wins over a clear
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fault_code <= FLT_NONE;
      end else if (fault_evt) begin
         fault_code <= fault_cause;
      end else if (fault_clr) begin
         fault_code <= FLT_NONE;
      end
   end

   // next mode from requests, pins and faults
   op_mode_e next_mode;
   always_comb begin
      next_mode = MODE_CHARGE;
      if ((hiz_req && !otg) || (min32_mode && input_undervoltage_lockout)) begin
         next_mode = MODE_HIZ;
      end else if (fault_evt) begin
         next_mode = MODE_CHG_CFG;
      end else if ((otg || boost_sel) && fault_code != FLT_OVERLOAD) begin
         next_mode = MODE_BOOST;
      end else if (fault_code != FLT_NONE) begin
         next_mode = MODE_CHG_CFG;
      end
   end

   // mode register; boost held off after a fault until out_ov, bat_ov and bat_min are low
   logic boost_armed;  // clears on fault, re-armed once out_ov, bat_ov and bat_min are low
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode <= MODE_CHARGE;
      end else if (next_mode == MODE_BOOST && !boost_armed) begin
         mode <= MODE_CHG_CFG;
      end else begin
         mode <= next_mode;
      end
   end

   // otg still held re-arms, except after an overload fault, which waits for fault clear; boost select was cleared so it needs a rewrite
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         boost_armed <= 1'b1;
      end else begin
         boost_armed <= !fault_evt && !out_ov && !bat_ov && !bat_min;
      end
   end

   assign boosting             = (mode == MODE_BOOST);
   assign boost_en_o           = boosting;
   assign pass_switch_linear_o = boosting && ovld;
   assign hiz_o                = (mode == MODE_HIZ);
   assign mode_o               = mode;

   // ****************************************
   // status pin pulse
   // ****************************************
   logic [12:0] pulse_cnt;  // remaining low-pulse cycles

   // one low pulse per fault, released otherwise
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pulse_cnt <= '0;
      end else if (fault_evt) begin
         pulse_cnt <= 13'(PULSE_CYC);
      end else if (pulse_cnt != 13'h0000) begin
         pulse_cnt <= pulse_cnt - 13'h0001;
      end
   end

   assign stat_out_o = 1'b0;
   assign stat_oe_o  = (pulse_cnt != 13'h0000);

endmodule

/* bench/boost_supervisor_chk.sv */
// assertion checker bound to the boost supervisor ports
`timescale 1ns/100ps
module boost_supervisor_chk
   import boost_supervisor_pkg::*;
(
   // clock and reset
   input wire logic                           core_clk_i,
   input wire logic                           rst_b_i,
   // comparators
   input wire logic                           out_ov_i,
   input wire logic                           overload_i,
   input wire logic                           bat_ov_i,
   input wire logic                           bat_min_i,
   // outputs watched
   input wire logic                           boost_en_o,
   input wire logic                           pass_switch_linear_o,
   input wire logic                           hiz_o,
   input wire boost_supervisor_pkg::op_mode_e mode_o,
   input wire logic                           stat_out_o,
   input wire logic                           stat_oe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   int unsigned pulse_cnt;  // cycles of the current low pulse
   logic        oe_q;       // pin enable one cycle back
   // count the length of each status pulse
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pulse_cnt <= 0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= stat_oe_o;
         if (stat_oe_o) begin
            pulse_cnt <= oe_q ? pulse_cnt + 1 : 1;
         end
      end
   end
   chk_pin_low: assert property (stat_oe_o |-> !stat_out_o)
      else $error("status pin driven high");
   chk_pulse_len: assert property ($fell(stat_oe_o) |-> pulse_cnt == PULSE_CYC)
      else $error("status pulse length wrong");
   chk_boost_drive: assert property (boost_en_o == (mode_o == MODE_BOOST))
      else $error("converter run disagrees with mode");
   chk_hiz_drive: assert property (hiz_o == (mode_o == MODE_HIZ))
      else $error("hi-z output disagrees with mode");
   chk_linear_boost: assert property (pass_switch_linear_o |-> mode_o == MODE_BOOST)
      else $error("linear pass switch outside boost");
   chk_ovld_linear: assert property ((mode_o == MODE_BOOST && overload_i && !out_ov_i)[*8]
      |-> pass_switch_linear_o)
      else $error("overload not current limited");
   chk_ov_stop: assert property ((mode_o == MODE_BOOST && out_ov_i) ##1 out_ov_i[*7]
      |-> mode_o != MODE_BOOST)
      else $error("boost kept running on overvoltage");
   chk_bat_stop: assert property ((mode_o == MODE_BOOST && (bat_ov_i || bat_min_i))
      ##1 (bat_ov_i || bat_min_i)[*7] |-> mode_o != MODE_BOOST)
      else $error("boost kept running on battery fault");
   chk_pulse_cause: assert property ($rose(stat_oe_o) |-> ##[0:2] mode_o != MODE_BOOST)
      else $error("fault pulse while boost runs");
endmodule
bind boost_supervisor boost_supervisor_chk chk_u (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .out_ov_i(out_ov_i), .overload_i(overload_i),
   .bat_ov_i(bat_ov_i), .bat_min_i(bat_min_i), .boost_en_o(boost_en_o),
   .pass_switch_linear_o(pass_switch_linear_o), .hiz_o(hiz_o), .mode_o(mode_o),
   .stat_out_o(stat_out_o), .stat_oe_o(stat_oe_o));

/* bench/host_model.sv */
// host side: avalon master cycles and the otg pin
`timescale 1ns/100ps
module host_model (
   input  wire logic        core_clk_i,
   input  wire logic [31:0] avs_readdata_i,
   input  wire logic        avs_waitrequest_i,
   output logic      [3:0]  avs_address_o,
   output logic             avs_read_o,
   output logic             avs_write_o,
   output logic      [31:0] avs_writedata_o,
   output logic             otg_active_o
);
   initial begin
      avs_address_o = 4'h0;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0000_0000;
      otg_active_o = 1'b0;
   end
   // restart by rewrite and fault clear both go through this write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= d;
      avs_write_o <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
      avs_write_o <= 1'b0;
   endtask
   // read data taken at the edge where waitrequest is low
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      avs_address_o <= a;
      avs_read_o <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
      d = avs_readdata_i;
      avs_read_o <= 1'b0;
   endtask
   // otg pin held by the host
   task automatic set_otg(input logic v);
      @(posedge core_clk_i);
      otg_active_o <= v;
   endtask
endmodule

/* bench/test_boost_supervisor.sv */
// self-checking bench for the boost supervisor
`timescale 1ns/100ps
module test_boost_supervisor;
   import boost_supervisor_pkg::*;
   logic        core_clk_i;
   logic        rst_b_i = 1'b0;
   logic [2:0]  flt = 3'h0;         // out ov, bat ov, bat min
   logic        overload = 1'b0;
   logic        bat_low = 1'b0;
   logic        input_undervoltage_lockout = 1'b0;
   logic [3:0]  addr;
   logic        rd_s, wr_s, otg, wreq, boost_en, lin, hiz, stat_out, stat_oe, irq;
   logic [31:0] wdata, rdata, rv;
   op_mode_e    mode;
   int          n_mismatch = 0;
   int          n_checks = 0;
   logic [31:0] codes [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0004};
   boost_supervisor dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
      .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .otg_active_i(otg), .out_ov_i(flt[0]), .overload_i(overload), .bat_ov_i(flt[1]),
      .bat_min_i(flt[2]), .bat_low_i(bat_low), .vin_input_undervoltage_lockout_i(input_undervoltage_lockout), .boost_en_o(boost_en),
      .pass_switch_linear_o(lin), .hiz_o(hiz), .mode_o(mode), .stat_out_o(stat_out),
      .stat_oe_o(stat_oe), .irq_o(irq));
   host_model host_u (.core_clk_i(core_clk_i), .avs_readdata_i(rdata),
      .avs_waitrequest_i(wreq), .avs_address_o(addr), .avs_read_o(rd_s),
      .avs_write_o(wr_s), .avs_writedata_o(wdata), .otg_active_o(otg));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      cmp_val({31'h0, got}, {31'h0, exp});
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      host_u.rd(a, rv);
      cmp_val(rv, exp);
   endtask
   task automatic wait_mode(input op_mode_e m);
      for (int i = 0; i < 40 && mode !== m; i++) @(negedge core_clk_i);
      cmp_val(32'(mode), 32'(m));
   endtask
   // one boost fault, then restart by rewrite or by held otg
   task automatic run_fault(input int k, input bit via_otg);
      int w;
      w = 0;
      if (via_otg) host_u.set_otg(1'b1);
      else host_u.wr(ADDR_CTRL, 32'h0000_0001);
      wait_mode(MODE_BOOST);
      @(posedge core_clk_i);
      flt[k] <= 1'b1;
      for (int i = 0; i < 50 && stat_oe !== 1'b1; i++) @(negedge core_clk_i);
      while (stat_oe === 1'b1 && w < 6000) begin
         w++;
         @(negedge core_clk_i);
      end
      cmp_val(32'(w), PULSE_CYC);
      cmp_val(32'(mode), 32'(MODE_CHG_CFG));
      cmp_pin(boost_en, 1'b0);
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      rd_chk(ADDR_STATUS, codes[k] | 32'h0000_0018);
      cmp_pin(irq, k != 0);
      host_u.wr(ADDR_IRQ_STAT, 32'h0000_0001);
      @(negedge core_clk_i);
      cmp_pin(irq, 1'b0);
      @(posedge core_clk_i);
      flt[k] <= 1'b0;
      repeat (20) @(negedge core_clk_i);
      if (via_otg) wait_mode(MODE_BOOST);
      else begin
         cmp_val(32'(mode), 32'(MODE_CHG_CFG));
         host_u.wr(ADDR_CTRL, 32'h0000_0001);
         wait_mode(MODE_BOOST);
      end
      host_u.set_otg(1'b0);
      host_u.wr(ADDR_CTRL, 32'h0000_0008);
      wait_mode(MODE_CHARGE);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
   endtask
   initial begin
      #(80000 * 25);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      int dur;
      void'($urandom(32'h0000_f11c));
      repeat (12) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
      rd_chk(ADDR_IRQ_MASK, 32'h0000_0000);
      host_u.wr(4'h2, $urandom);
      rd_chk(4'h2, 32'h0000_0000);
      run_fault(0, 1'b0);
      host_u.wr(ADDR_IRQ_MASK, 32'h0000_0003);
      rd_chk(ADDR_IRQ_MASK, 32'h0000_0003);
      run_fault(1, 1'b1);
      run_fault(2, 1'b1);
      // short overload: limit but no fault
      dur = 200 + ($urandom % 2000);
      host_u.wr(ADDR_CTRL, 32'h0000_0001);
      wait_mode(MODE_BOOST);
      @(posedge core_clk_i);
      overload <= 1'b1;
      repeat (20) @(negedge core_clk_i);
      cmp_pin(lin, 1'b1);
      repeat (dur) @(negedge core_clk_i);
      cmp_val(32'(mode), 32'(MODE_BOOST));
      cmp_pin(stat_oe, 1'b0);
      @(posedge core_clk_i);
      overload <= 1'b0;
      host_u.wr(ADDR_CTRL, 32'h0000_0002);
      bat_low <= 1'b1;
      wait_mode(MODE_HIZ);
      cmp_pin(hiz, 1'b1);
      rd_chk(ADDR_CTRL, 32'h0000_0002);
      host_u.wr(ADDR_CTRL, 32'h0000_0000);
      wait_mode(MODE_CHARGE);
      end_of_test();
   end
endmodule
